// >>> hw/dei_irq_status.sv
// dsp event interrupt status bank: sticky flags, masks, apb slave, interrupt
// Notes on behaviour
// - start-1 flags at 181Ah, core N at bit N-1
// - start-2 flags at 181Bh, core N at bit N-1
// - busy flags at 181Dh, cores 7..4 bits 6..3
// - flag sets on source rise, then stays
// - writing one clears flag, zero leaves it
// - all flags read zero after reset
// - mask bit per flag, one blocks it
`timescale 1ns/100ps
`default_nettype none
`include "dei_consts.svh"
module dei_irq_status
	import dei_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// event sources from the dsp cores
	input wire logic core1_transfer_event_i,
	input wire logic [6:0] core_first_start_i,
	input wire logic [6:0] core_second_start_i,
	input wire logic [3:0] core_busy_hi_i,
	// interrupt request
	output logic irq_o
);
	// ***********************************************
	// address decode
	// ***********************************************
	dei_sel_type sel; // register picked by paddr
	logic [15:0] word_idx; // register index from byte address
	logic aligned; // low address bits zero

	// byte address to index, then index to register
	always_comb begin
		word_idx = {2'b00, paddr_i[15:2]};
		aligned = (paddr_i[1:0] == 2'b00);
		sel = SEL_NONE;
		if (aligned) begin
			case (word_idx)
				`DEI_IDX_XFER: sel = SEL_XFER;
				`DEI_IDX_START1: sel = SEL_START1;
				`DEI_IDX_START2: sel = SEL_START2;
				`DEI_IDX_BUSY: sel = SEL_BUSY;
				`DEI_IDX_XFER + `DEI_IDX_MASK_OFS: sel = SEL_MASK_XFER;
				`DEI_IDX_START1 + `DEI_IDX_MASK_OFS: sel = SEL_MASK_START1;
				`DEI_IDX_START2 + `DEI_IDX_MASK_OFS: sel = SEL_MASK_START2;
				`DEI_IDX_BUSY + `DEI_IDX_MASK_OFS: sel = SEL_MASK_BUSY;
				default: begin
					// rest of the mask bank reads zero without error
					if (word_idx >= `DEI_IDX_MASK_FIRST && word_idx <= `DEI_IDX_MASK_LAST) begin
						sel = SEL_MASK_SPARE;
					end
				end
			endcase
		end
	end

	// ***********************************************
	// apb handshake
	// ***********************************************
	logic setup_ph; // first cycle of a transfer
	logic access_ph; // completing cycle, zero wait states
	logic wr_lane0; // write that reaches the low byte

	// every access finishes in its first access cycle
	always_comb begin
		setup_ph = psel_i & ~penable_i;
		access_ph = psel_i & penable_i;
		wr_lane0 = access_ph & pwrite_i & pstrb_i[0];
		pready_o = 1'b1;
		pslverr_o = access_ph & (sel == SEL_NONE);
	end

	// ***********************************************
	// write-one-to-clear pulses
	// ***********************************************
	logic clr_xfer; // clear of the transfer flag
	dei_core_vec_type clr_start1; // clears of start-1 flags
	dei_core_vec_type clr_start2; // clears of start-2 flags
	logic [3:0] clr_busy; // clears of busy flags, cores 7..4

	// a one in a data bit clears, a zero leaves the flag
	always_comb begin
		clr_xfer = 1'b0;
		clr_start1 = '0;
		clr_start2 = '0;
		clr_busy = '0;
		if (wr_lane0) begin
			case (sel)
				SEL_XFER: clr_xfer = pwdata_i[`DEI_XFER_BIT];
				SEL_START1: clr_start1 = pwdata_i[6:0];
				SEL_START2: clr_start2 = pwdata_i[6:0];
				SEL_BUSY: clr_busy = pwdata_i[6:`DEI_BUSY_LSB];
				default: begin
					// other registers hold no flags
				end
			endcase
		end
	end

	// ***********************************************
	// sticky flag banks
	// ***********************************************
	logic xfer_flag; // core 1 transfer flag
	dei_core_vec_type start1_flags; // start-1 flag per core
	dei_core_vec_type start2_flags; // start-2 flag per core
	logic [3:0] busy_flags; // busy flags of cores 7..4

	// transfer flag of core 1
	dei_edge_flag #(.W(1)) u_xfer (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.src_i(core1_transfer_event_i),
		.clear_i(clr_xfer),
		.flag_o(xfer_flag)
	);
	// start-1 flags, core N at bit N-1
	dei_edge_flag #(.W(`DEI_CORES)) u_start1 (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.src_i(core_first_start_i),
		.clear_i(clr_start1),
		.flag_o(start1_flags)
	);
	// start-2 flags, core N at bit N-1
	dei_edge_flag #(.W(`DEI_CORES)) u_start2 (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.src_i(core_second_start_i),
		.clear_i(clr_start2),
		.flag_o(start2_flags)
	);
	// busy flags of cores 7..4
	dei_edge_flag #(.W(`DEI_BUSY_CORES)) u_busy (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.src_i(core_busy_hi_i),
		.clear_i(clr_busy),
		.flag_o(busy_flags)
	);

	// ***********************************************
	// mask registers
	// ***********************************************
	logic mask_xfer_q; // one blocks the transfer flag
	logic mask_xfer_d;
	dei_core_vec_type mask_start1_q; // one blocks a start-1 flag
	dei_core_vec_type mask_start1_d;
	dei_core_vec_type mask_start2_q; // one blocks a start-2 flag
	dei_core_vec_type mask_start2_d;
	logic [3:0] mask_busy_q; // one blocks a busy flag
	logic [3:0] mask_busy_d;

	// plain read-write masks, written on the completing cycle
	always_comb begin
		mask_xfer_d = mask_xfer_q;
		mask_start1_d = mask_start1_q;
		mask_start2_d = mask_start2_q;
		mask_busy_d = mask_busy_q;
		if (wr_lane0) begin
			case (sel)
				SEL_MASK_XFER: mask_xfer_d = pwdata_i[`DEI_XFER_BIT];
				SEL_MASK_START1: mask_start1_d = pwdata_i[6:0];
				SEL_MASK_START2: mask_start2_d = pwdata_i[6:0];
				SEL_MASK_BUSY: mask_busy_d = pwdata_i[6:`DEI_BUSY_LSB];
				default: begin
					// no mask selected
				end
			endcase
		end
	end

	// masks come out of reset blocking every flag
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			mask_xfer_q <= 1'(`DEI_MASK_RST);
			mask_start1_q <= `DEI_MASK_RST;
			mask_start2_q <= `DEI_MASK_RST;
			mask_busy_q <= 4'(`DEI_MASK_RST);
		end else begin
			mask_xfer_q <= mask_xfer_d;
			mask_start1_q <= mask_start1_d;
			mask_start2_q <= mask_start2_d;
			mask_busy_q <= mask_busy_d;
		end
	end

	// ***********************************************
	// read data
	// ***********************************************
	logic [31:0] prdata_q; // registered read word
	logic [31:0] prdata_d;

	// capture the word in the setup cycle, shown in the access cycle
	always_comb begin
		prdata_d = prdata_q;
		if (setup_ph) begin
			prdata_d = 32'h0000_0000;
			case (sel)
				SEL_XFER: prdata_d[`DEI_XFER_BIT] = xfer_flag;
				SEL_START1: prdata_d[6:0] = start1_flags;
				SEL_START2: prdata_d[6:0] = start2_flags;
				SEL_BUSY: prdata_d[6:`DEI_BUSY_LSB] = busy_flags;
				SEL_MASK_XFER: prdata_d[`DEI_XFER_BIT] = mask_xfer_q;
				SEL_MASK_START1: prdata_d[6:0] = mask_start1_q;
				SEL_MASK_START2: prdata_d[6:0] = mask_start2_q;
				SEL_MASK_BUSY: prdata_d[6:`DEI_BUSY_LSB] = mask_busy_q;
				default: begin
					// spare mask words and unmapped addresses read zero
				end
			endcase
		end
	end

	// read register
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			prdata_q <= 32'h0000_0000;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	assign prdata_o = prdata_q;

	// ***********************************************
	// interrupt request
	// ***********************************************
	logic pending_any; // some unmasked flag is set

	// level request, drops once all flags are cleared or masked
	always_comb begin
		pending_any = (xfer_flag & ~mask_xfer_q)
			| (|(start1_flags & ~mask_start1_q))
			| (|(start2_flags & ~mask_start2_q))
			| (|(busy_flags & ~mask_busy_q));
		irq_o = pending_any;
	end

	// ***********************************************
	// assertions
	// ***********************************************
	default clocking dei_cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	// edge detectors start as if high, so a rise on the first cycle after reset sets nothing
	// a rise of core 7 start-1 shows in bit 6 one cycle later
	a_start1_core7_set: assert property ((!$past(sys_rst_i) && $rose(core_first_start_i[6])) |=> start1_flags[6])
		else $error("core 7 start-1 rise did not set bit 6");
	// a rise of core 1 start-2 shows in bit 0 one cycle later
	a_start2_core1_set: assert property ((!$past(sys_rst_i) && $rose(core_second_start_i[0])) |=> start2_flags[0])
		else $error("core 1 start-2 rise did not set bit 0");
	// a read of the busy word returns core 4 in bit 3
	a_busy_read_bit: assert property ((setup_ph && sel == SEL_BUSY) |=> prdata_o[3] == $past(busy_flags[0]))
		else $error("busy word bit 3 does not show core 4");
	// without a rise a clear flag stays clear
	a_no_set_idle: assert property ((!start1_flags[1] && !$rose(core_first_start_i[1])) |=> !start1_flags[1])
		else $error("start-1 core 2 flag set without a rise");
	// a set flag holds into the next cycle while nothing clears it
	a_flag_holds: assert property ((start2_flags[3] && clr_start2[3] == 1'b0) |=> start2_flags[3])
		else $error("start-2 core 4 flag dropped without a clear");
	// writing one to bit 2 clears it unless a new rise arrives
	a_w1c_clears: assert property ((wr_lane0 && sel == SEL_START1 && pwdata_i[2]
		&& !(core_first_start_i[2] && !$past(core_first_start_i[2]))) |=> !start1_flags[2])
		else $error("write of one did not clear start-1 core 3");
	// writing zero leaves a set flag alone
	a_zero_keeps: assert property ((wr_lane0 && sel == SEL_START1 && !pwdata_i[1] && start1_flags[1]) |=> start1_flags[1])
		else $error("write of zero cleared start-1 core 2");
	// after reset every flag reads zero
	a_reset_zero: assert property (@(posedge clock_i) disable iff (1'b0)
		sys_rst_i |=> (start1_flags == 7'h00 && start2_flags == 7'h00 && busy_flags == 4'h0 && !xfer_flag))
		else $error("flags not zero after reset");
	// with everything masked the request stays low
	a_mask_blocks: assert property ((mask_xfer_q && mask_start1_q == 7'h7f && mask_start2_q == 7'h7f
		&& mask_busy_q == 4'hf) |-> !irq_o)
		else $error("interrupt raised while all flags masked");
	// an unmasked rise raises the request on the next cycle
	a_irq_raise: assert property ((!$past(sys_rst_i) && $rose(core_first_start_i[3]) && !mask_start1_q[3] && !clr_start1[3]
		&& !(wr_lane0 && sel == SEL_MASK_START1)) |=> irq_o)
		else $error("unmasked start-1 core 4 event gave no interrupt");

	// main scenarios
	c_flag_set: cover property ($rose(core_busy_hi_i[3]) ##1 busy_flags[3]);
	c_flag_cleared: cover property (start1_flags[0] ##1 (wr_lane0 && sel == SEL_START1) ##1 !start1_flags[0]);
	c_irq_seen: cover property ($rose(irq_o));
	c_irq_dropped: cover property ($fell(irq_o));
	c_unmapped: cover property (pslverr_o);
endmodule // dei_irq_status
`default_nettype wire

// >>> hw/dei_consts.svh
// constants of the dsp event interrupt status block: indices, reset values, widths
`ifndef DEI_CONSTS_SVH
`define DEI_CONSTS_SVH

// ***********************************************
// register indices (byte address is four times the index)
// ***********************************************
`define DEI_IDX_XFER 16'h1818
`define DEI_IDX_START1 16'h181a
`define DEI_IDX_START2 16'h181b
`define DEI_IDX_BUSY 16'h181d
`define DEI_IDX_MASK_FIRST 16'h1840
`define DEI_IDX_MASK_LAST 16'h185f
`define DEI_IDX_MASK_OFS 16'h0028

// ***********************************************
// field layout and reset values
// ***********************************************
`define DEI_CORES 7
`define DEI_BUSY_CORES 4
`define DEI_BUSY_LSB 3
`define DEI_XFER_BIT 0
`define DEI_FLAG_RST 7'h00
`define DEI_MASK_RST 7'h7f
`define DEI_PREV_RST 7'h7f

`endif

// >>> hw/dei_pkg.sv
// types shared by the dsp event interrupt status block
package dei_pkg;
	// register selected by the current apb address
	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_XFER,
		SEL_START1,
		SEL_START2,
		SEL_BUSY,
		SEL_MASK_XFER,
		SEL_MASK_START1,
		SEL_MASK_START2,
		SEL_MASK_BUSY,
		SEL_MASK_SPARE
	} dei_sel_type;
	// one bit per dsp core
	typedef logic [6:0] dei_core_vec_type;
endpackage

// >>> hw/dei_edge_flag.sv
// sticky rising-edge flags with write-one-to-clear
`timescale 1ns/100ps
`default_nettype none
`include "dei_consts.svh"
module dei_edge_flag #(
	parameter int W = 7
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] src_i,
	input wire logic [W-1:0] clear_i,
	output logic [W-1:0] flag_o
);
	// ***********************************************
	// state
	// ***********************************************
	logic [W-1:0] prev_q; // source seen one cycle ago
	logic [W-1:0] prev_d;
	logic [W-1:0] flag_q; // sticky flags
	logic [W-1:0] flag_d;

	// next values: a rise sets, a one written clears, the set wins
	always_comb begin
		prev_d = src_i;
		flag_d = (flag_q & ~clear_i) | (src_i & ~prev_q);
	end

	// registers; prev starts high so a source already high at reset is no edge
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			prev_q <= W'(`DEI_PREV_RST);
			flag_q <= W'(`DEI_FLAG_RST);
		end else begin
			prev_q <= prev_d;
			flag_q <= flag_d;
		end
	end

	assign flag_o = flag_q;
endmodule // dei_edge_flag
`default_nettype wire

// >>> bench/tb_dsp_event_irq_status.sv
// self-checking testbench of the dsp event interrupt status bank
`timescale 1ns/100ps
`default_nettype none
`include "dei_consts.svh"
module tb_dsp_event_irq_status
	import dei_pkg::*;
;
	// ***********************************************
	// signals and table
	// ***********************************************
	logic clock, rst, psel, penable, pwrite, pready, pslverr, irq, xfer_src; // apb and misc pins
	logic [15:0] paddr; // byte address
	logic [31:0] pwdata, prdata, rd; // apb data
	logic [3:0] pstrb, busy_src; // strobes, busy sources of cores 7..4
	logic [6:0] first_src, second_src; // start sources
	logic er; // error seen on the last transfer
	int n_mismatch, checked; // counters
	typedef struct {int kind; logic [6:0] src; logic [6:0] exp;} dei_row_type;
	// kind: 0 transfer, 1 start-1, 2 start-2, 3 busy; source pattern placed at its flag bits
	dei_row_type rows [7] = '{'{0, 7'h01, 7'h01}, '{1, 7'h40, 7'h40}, '{1, 7'h01, 7'h01},
		'{2, 7'h48, 7'h48}, '{2, 7'h01, 7'h01}, '{3, 7'h40, 7'h40}, '{3, 7'h08, 7'h08}};
	int idx [4] = '{`DEI_IDX_XFER, `DEI_IDX_START1, `DEI_IDX_START2, `DEI_IDX_BUSY};

	dei_irq_status dut (.clock_i(clock), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .core1_transfer_event_i(xfer_src),
		.core_first_start_i(first_src), .core_second_start_i(second_src), .core_busy_hi_i(busy_src),
		.irq_o(irq));

	// ***********************************************
	// tasks
	// ***********************************************
	// compares and counts
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1);
		// the slave answers in its first access cycle; only the watchdog ends a hang
		check("access cycles", n, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// flag and mask byte addresses
	function automatic logic [15:0] fa(input int k);
		return 16'(idx[k] * 4);
	endfunction
	function automatic logic [15:0] ma(input int k);
		return 16'((idx[k] + `DEI_IDX_MASK_OFS) * 4);
	endfunction

	// drives the source group of one kind
	task automatic set_src(input int k, input logic [6:0] v);
		case (k)
			0: xfer_src <= v[0];
			1: first_src <= v;
			2: second_src <= v;
			default: busy_src <= v[6:3];
		endcase
	endtask

	// one-cycle source pulse
	task automatic pulse(input int k, input logic [6:0] v);
		@(posedge clock);
		set_src(k, v);
		@(posedge clock);
		set_src(k, 7'h00);
		@(posedge clock);
	endtask

	// reads one flag register and compares
	task automatic rdchk(input string name, input logic [15:0] a, input logic [6:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, rd, {25'h0, exp});
	endtask

	// prints counts and verdict, ends the run
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ***********************************************
	// clock, watchdog, tests
	// ***********************************************
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// cuts a hang short; the tests need well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clock);
		n_mismatch++;
		complete_run;
	end

	initial begin
		{psel, penable, pwrite, xfer_src, first_src, second_src, busy_src} = '0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		rst = 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		// reset values
		for (int k = 0; k < 4; k++) rdchk("flag at reset", fa(k), 7'h00);
		check("irq at reset", {31'h0, irq}, 32'h0);
		rdchk("mask at reset", ma(1), 7'h7f);
		$display("test reset done");
		// table: set by a rise, read at its bit, clear by writing ones
		foreach (rows[i]) begin
			pulse(rows[i].kind, rows[i].src);
			rdchk("flag set", fa(rows[i].kind), rows[i].exp);
			apb(1'b1, fa(rows[i].kind), {25'h0, rows[i].exp});
			rdchk("flag cleared", fa(rows[i].kind), 7'h00);
		end
		$display("test table done");
		// level held high: partial clear, zero write, no re-set without a new rise
		@(posedge clock);
		first_src <= 7'h7f;
		rdchk("held flags", fa(1), 7'h7f);
		apb(1'b1, fa(1), 32'h05);
		rdchk("partial clear", fa(1), 7'h7a);
		apb(1'b1, fa(1), 32'h00);
		rdchk("zero write", fa(1), 7'h7a);
		apb(1'b1, fa(1), 32'h7f);
		rdchk("no re-set on level", fa(1), 7'h00);
		first_src <= 7'h00;
		$display("test level done");
		// interrupt masking
		pulse(2, 7'h01);
		check("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, ma(2), 32'h7e);
		#1 check("irq unmasked", {31'h0, irq}, 32'h1);
		apb(1'b1, ma(2), 32'h7f);
		#1 check("irq remasked", {31'h0, irq}, 32'h0);
		apb(1'b1, ma(2), 32'h7e);
		apb(1'b1, fa(2), 32'h01);
		#1 check("irq after clear", {31'h0, irq}, 32'h0);
		apb(1'b1, ma(1), 32'h77);
		pulse(1, 7'h08);
		check("irq start-1 core 4", {31'h0, irq}, 32'h1);
		apb(1'b1, fa(1), 32'h08);
		#1 check("irq start-1 cleared", {31'h0, irq}, 32'h0);
		apb(1'b1, ma(1), 32'h7f);
		$display("test interrupt done");
		// refused accesses: unmapped, misaligned, strobe low
		apb(1'b0, 16'h0000, 32'h0);
		check("unmapped error", {31'h0, er}, 32'h1);
		apb(1'b0, fa(1) + 16'h1, 32'h0);
		check("misaligned error", {31'h0, er}, 32'h1);
		pulse(1, 7'h01);
		pstrb <= 4'he;
		apb(1'b1, fa(1), 32'h01);
		rdchk("strobe off write", fa(1), 7'h01);
		pstrb <= 4'hf;
		$display("test refusals done");
		// reset in mid-run
		pulse(3, 7'h78);
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		for (int k = 1; k < 4; k++) rdchk("flag after reset", fa(k), 7'h00);
		rdchk("mask after reset", ma(2), 7'h7f);
		check("irq after reset", {31'h0, irq}, 32'h0);
		$display("test second reset done");
		complete_run;
	end
endmodule // tb_dsp_event_irq_status
`default_nettype wire
